// ---- sacc_pkg.sv ----
// Purpose: Shared constants for the converter control block
// Assumes: 10 MHz core clock, byte-wide register port
// Notes: Offsets are register indexes on the plain port
package sacc_pkg;
  localparam int unsigned SACC_CLK_HZ = 10000000;
  localparam logic [7:0] SACC_OFS_CTRL = 8'h08;
  localparam logic [7:0] SACC_OFS_PCFG = 8'h9f;
  localparam logic [7:0] SACC_OFS_RESULT = 8'h1e;
  localparam logic [7:0] SACC_OFS_IRQ_STAT = 8'h40;
  localparam logic [7:0] SACC_OFS_IRQ_MASK = 8'h41;
  localparam logic [7:0] SACC_OFS_AUX = 8'h42;
  localparam int SACC_BIT_ON = 0;
  localparam int SACC_BIT_DONE = 1;
  localparam int SACC_BIT_GO = 2;
  localparam int SACC_BIT_GP = 5;
  localparam logic [7:0] SACC_CTRL_RST = 8'h00;
  localparam logic [7:0] SACC_CTRL_WMASK_GP = 8'hff;
  localparam logic [7:0] SACC_CTRL_WMASK_NOGP = 8'hdf;
  localparam logic [1:0] SACC_PCFG_RST = 2'h0;
  localparam logic [1:0] SACC_CLK_DIV2 = 2'h0;
  localparam logic [1:0] SACC_CLK_DIV32 = 2'h2;
  localparam logic [1:0] SACC_CLK_RC = 2'h3;
  localparam logic [5:0] SACC_DIV2_TERM = 6'h01;
  localparam logic [5:0] SACC_DIV8_TERM = 6'h07;
  localparam logic [5:0] SACC_DIV32_TERM = 6'h1f;
  localparam logic [5:0] SACC_RC_TERM = 6'h03;
  localparam logic [1:0] SACC_INSTR_CYCLES = 2'h3;
  localparam int SACC_RES_W = 8;
  localparam logic [3:0] SACC_SAMPLE_PERIODS = 4'h2;
endpackage

// ---- sacc_result_mem.sv ----
// Purpose: Result holding register, not touched by reset
// Assumes: Single clock
// Notes: Content is unknown until first conversion completes
`timescale 1ns/1ps
module sacc_result_mem #(
  parameter int WIDTH = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_we,
  input wire logic [WIDTH-1:0] i_wdata,
  output logic [WIDTH-1:0] o_rdata
);
  logic [WIDTH-1:0] store_reg;
  // No reset on purpose: value survives every reset
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      store_reg <= i_wdata;
    end
  end
  assign o_rdata = store_reg;
endmodule

// ---- sacc_top.sv ----
// Purpose: Successive approximation converter control and register file
// Assumes: Comparator output is sampled synchronously; sleep is a level input
// Notes: Result register is kept in a reset-free holding module
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

module sacc_top
  import sacc_pkg::*;
#(
  parameter int RES_W = SACC_RES_W,
  parameter bit HAS_GP_BIT = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_sleep,
  input wire logic i_int_en,
  input wire logic i_cmp,
  output logic [RES_W-1:0] o_dac_code,
  output logic [1:0] o_chan_sel,
  output logic o_ref_pin_sel,
  output logic [1:0] o_pin_func,
  output logic o_analog_pwr,
  output logic o_sample,
  output logic o_wake,
  output logic o_irq
);
  typedef enum {SACC_IDLE, SACC_DELAY, SACC_SAMPLE, SACC_CONV} sacc_state_t;

  sacc_state_t state_reg, state_next;
  logic [7:0] ctrl_reg;
  logic [1:0] pcfg_reg;
  logic ref_sel_reg;
  logic irq_stat_reg;
  logic irq_mask_reg;
  logic [5:0] div_reg;
  logic [1:0] dly_reg;
  logic [3:0] samp_reg;
  logic [RES_W-1:0] sar_reg;
  logic [RES_W-1:0] bit_reg;
  logic [RES_W-1:0] result_q;
  logic [7:0] rdata_reg;
  logic [RES_W-1:0] dac_reg;
  logic [1:0] chan_reg;
  logic ref_out_reg;
  logic [1:0] pinf_reg;
  logic pwr_reg;
  logic sample_reg;
  logic wake_reg;
  logic irq_reg;

  wire sel_ctrl = (i_addr == SACC_OFS_CTRL);
  wire sel_pcfg = (i_addr == SACC_OFS_PCFG);
  wire sel_res = (i_addr == SACC_OFS_RESULT);
  wire sel_stat = (i_addr == SACC_OFS_IRQ_STAT);
  wire sel_mask = (i_addr == SACC_OFS_IRQ_MASK);
  wire sel_aux = (i_addr == SACC_OFS_AUX);
  wire wr_ctrl = i_wr && sel_ctrl;
  wire [7:0] ctrl_wmask = HAS_GP_BIT ? SACC_CTRL_WMASK_GP : SACC_CTRL_WMASK_NOGP;
  wire [1:0] clk_sel = ctrl_reg[7:6];
  wire conv_on = ctrl_reg[SACC_BIT_ON];
  wire is_rc = (clk_sel == SACC_CLK_RC);
  wire busy = (state_reg != SACC_IDLE);
  // Powered down while asleep without RC clock, ON bit stays set
  wire sleep_abort = i_sleep && !is_rc;
  wire start_req = wr_ctrl && i_wdata[SACC_BIT_GO] && i_wdata[SACC_BIT_ON] && !busy;
  // The clock select written with go decides the delay, not the one it replaces
  wire start_rc = (i_wdata[7:6] == SACC_CLK_RC);
  wire abort = !conv_on || sleep_abort;
  // Code 01 is undefined; it is run at div8 rather than stalling
  wire [5:0] div_term = (clk_sel == SACC_CLK_DIV2) ? SACC_DIV2_TERM :
                        (clk_sel == SACC_CLK_DIV32) ? SACC_DIV32_TERM :
                        is_rc ? SACC_RC_TERM : SACC_DIV8_TERM;
  wire tick = (div_reg == div_term);
  wire last_bit = bit_reg[0];
  wire finish = (state_reg == SACC_CONV) && tick && last_bit && !abort;
  wire [RES_W-1:0] trial = sar_reg | bit_reg;
  wire [RES_W-1:0] kept = i_cmp ? sar_reg : (sar_reg & ~bit_reg);
  wire [RES_W-1:0] sar_done = kept;
  wire done_set = finish;
  wire stat_clr = i_wr && sel_stat && i_wdata[0];
  wire [7:0] ctrl_rd = {ctrl_reg[7:6], HAS_GP_BIT ? ctrl_reg[5] : 1'b0, ctrl_reg[4:3],
                        busy, ctrl_reg[1:0]};
  wire [7:0] rd_mux = sel_ctrl ? ctrl_rd :
                      sel_pcfg ? {6'h00, pcfg_reg} :
                      sel_res ? result_q :
                      sel_stat ? {7'h00, irq_stat_reg} :
                      sel_mask ? {7'h00, irq_mask_reg} :
                      sel_aux ? {7'h00, ref_sel_reg} : 8'h00;
  wire [7:0] ctrl_wr_val = (ctrl_reg & ~ctrl_wmask) | (i_wdata & ctrl_wmask);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SACC_IDLE: begin
        if (start_req) begin
          state_next = start_rc ? SACC_DELAY : SACC_SAMPLE;
        end
      end
      SACC_DELAY: begin
        if (abort) begin
          state_next = SACC_IDLE;
        end else if (dly_reg == SACC_INSTR_CYCLES) begin
          state_next = SACC_SAMPLE;
        end
      end
      SACC_SAMPLE: begin
        if (abort) begin
          state_next = SACC_IDLE;
        end else if (tick && samp_reg == SACC_SAMPLE_PERIODS) begin
          state_next = SACC_CONV;
        end
      end
      SACC_CONV: begin
        if (abort || (tick && last_bit)) begin
          state_next = SACC_IDLE;
        end
      end
      default: state_next = SACC_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= SACC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Done flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= SACC_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_wr_val & ~8'h04;
      end
      if (done_set) begin
        ctrl_reg[SACC_BIT_DONE] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pcfg_reg <= SACC_PCFG_RST;
      ref_sel_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
    end else begin
      if (i_wr && sel_pcfg) begin
        pcfg_reg <= i_wdata[1:0];
      end
      if (i_wr && sel_aux) begin
        ref_sel_reg <= i_wdata[0];
      end
      if (i_wr && sel_mask) begin
        irq_mask_reg <= i_wdata[0];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_reg <= 1'b0;
    end else if (done_set) begin
      irq_stat_reg <= 1'b1;
    end else if (stat_clr) begin
      irq_stat_reg <= 1'b0;
    end
  end

  // Bit clock divider runs only in the sample and convert states, held at zero in the RC delay
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_reg <= 6'h00;
    end else if (!busy || tick || state_reg == SACC_DELAY) begin
      div_reg <= 6'h00;
    end else begin
      div_reg <= div_reg + 6'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dly_reg <= 2'h0;
      samp_reg <= 4'h0;
    end else begin
      dly_reg <= (state_reg == SACC_DELAY) ? dly_reg + 2'h1 : 2'h0;
      if (state_reg != SACC_SAMPLE) begin
        samp_reg <= 4'h0;
      end else if (tick) begin
        samp_reg <= samp_reg + 4'h1;
      end
    end
  end

  // Successive approximation, MSB first
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sar_reg <= '0;
      bit_reg <= '0;
    end else if (state_reg == SACC_SAMPLE) begin
      sar_reg <= {1'b1, {(RES_W-1){1'b0}}};
      bit_reg <= {1'b1, {(RES_W-1){1'b0}}};
    end else if (state_reg == SACC_CONV && tick) begin
      sar_reg <= (kept | (bit_reg >> 1));
      bit_reg <= bit_reg >> 1;
    end
  end

  sacc_result_mem #(
    .WIDTH(RES_W)
  ) u_result (
    .i_ref_clk(i_ref_clk),
    .i_we(finish),
    .i_wdata(sar_done),
    .o_rdata(result_q)
  );

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= 8'h00;
      dac_reg <= '0;
      chan_reg <= 2'h0;
      ref_out_reg <= 1'b0;
      pinf_reg <= 2'h0;
      pwr_reg <= 1'b0;
      sample_reg <= 1'b0;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      rdata_reg <= i_rd ? rd_mux : 8'h00;
      dac_reg <= (state_reg == SACC_CONV) ? trial : '0;
      chan_reg <= ctrl_reg[4:3];
      ref_out_reg <= ref_sel_reg;
      pinf_reg <= pcfg_reg;
      pwr_reg <= conv_on && !sleep_abort;
      sample_reg <= (state_reg == SACC_SAMPLE);
      wake_reg <= done_set && i_sleep && i_int_en;
      // Set path folded in so the line rises together with the status flag
      irq_reg <= (irq_stat_reg && irq_mask_reg) || (done_set && irq_mask_reg);
    end
  end

  assign o_rdata = rdata_reg;
  assign o_dac_code = dac_reg;
  assign o_chan_sel = chan_reg;
  assign o_ref_pin_sel = ref_out_reg;
  assign o_pin_func = pinf_reg;
  assign o_analog_pwr = pwr_reg;
  assign o_sample = sample_reg;
  assign o_wake = wake_reg;
  assign o_irq = irq_reg;

  // A start may switch power on in the same write, so it is excluded here
  rst_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !conv_on && !start_req |=> !busy) else $error("busy while powered off");
  pwr_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !conv_on |=> !o_analog_pwr) else $error("powered while off");
  stat_set_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    done_set |=> irq_stat_reg) else $error("status not set");
  go_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    start_req |=> busy) else $error("start ignored");
  rc_delay_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    start_req && start_rc |=> state_reg == SACC_DELAY) else $error("no rc delay");
  done_flag_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    finish |=> ctrl_reg[SACC_BIT_DONE] && !busy) else $error("done not flagged");
  result_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    finish |=> result_q == $past(sar_done)) else $error("result not loaded");
  sleep_abort_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    sleep_abort && busy |=> !busy && !o_analog_pwr) else $error("sleep abort failed");
  wake_pulse_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    finish && i_sleep && i_int_en |=> o_wake) else $error("no wake");
  chan_out_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ##1 o_chan_sel == $past(ctrl_reg[4:3])) else $error("channel mismatch");
  gp_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_rd && sel_ctrl |=> o_rdata[SACC_BIT_GP] == (HAS_GP_BIT && $past(ctrl_reg[SACC_BIT_GP])))
    else $error("bit5 readback wrong");
  pcfg_rst_a: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(i_rstn) |-> pcfg_reg == SACC_PCFG_RST) else $error("pin config reset");
  conv_c: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) finish);
  sleep_c: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) finish && i_sleep);
  abort_c: cover property (@(posedge i_ref_clk) disable iff (!i_rstn) sleep_abort && busy);
  rc_start_c: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
    start_req && start_rc);
  wake_c: cover property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_wake);
endmodule

// ---- test_sacc_top.sv ----
// Purpose: Self-checking bench for the converter control block
// Assumes: Ideal comparator modelled from an integer input level
// Notes: Mode timing is compared as differences so fixed pipeline offsets cancel
`timescale 1ns/1ps
module test_sacc_top;
  import sacc_pkg::*;
  logic i_ref_clk, i_rstn, i_wr, i_rd, i_sleep, i_int_en, i_cmp;
  logic [7:0] i_addr, i_wdata, o_rdata, o_dac_code, vin, d;
  logic [1:0] o_chan_sel, o_pin_func;
  logic o_ref_pin_sel, o_analog_pwr, o_sample, o_wake, o_irq;
  int error_cnt, n_checks, cyc, wake_n, samp_n, s, e, ts[3], te[3], k;
  // Rows: address, write data, read-back, visible output
  logic [31:0] rows[10] = '{32'h08010100, 32'h08090901, 32'h08111102, 32'h08191903, 32'h08e8e801,
    32'h9fff0303, 32'h9f020202, 32'h42010101, 32'h77ff0000, 32'h41ff0100};
  // Bit periods of 2, 32 and 4 clocks stay well under the upper limit
  logic [1:0] ckt[3] = '{SACC_CLK_DIV2, SACC_CLK_DIV32, SACC_CLK_RC};
  logic [7:0] vt[3] = '{8'ha5, 8'h00, 8'hff};
  // Comparator follows the trial code at once, as the analog side would
  assign i_cmp = (vin >= o_dac_code);
  sacc_top dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_sleep(i_sleep), .i_int_en(i_int_en), .i_cmp(i_cmp),
    .o_dac_code(o_dac_code), .o_chan_sel(o_chan_sel), .o_ref_pin_sel(o_ref_pin_sel), .o_pin_func(o_pin_func),
    .o_analog_pwr(o_analog_pwr), .o_sample(o_sample), .o_wake(o_wake), .o_irq(o_irq));
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  // Whole run is under a thousand cycles; the 20000-cycle ceiling leaves wide margin
  always @(posedge i_ref_clk) begin
    cyc <= cyc + 1;
    if (o_wake === 1'b1) wake_n <= wake_n + 1;
    if (o_sample === 1'b1) samp_n <= samp_n + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= w;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    q = o_rdata;
  endtask
  task automatic wait_on(input bit irq);
    int t;
    t = cyc;
    while (((irq ? o_irq : o_sample) !== 1'b1) && cyc - t < 1000) begin
      @(posedge i_ref_clk);
      #1;
    end
    chk(cyc - t < 1000, 1);
  endtask
  task automatic conv(input logic [1:0] ck, input logic [1:0] ch, input logic [7:0] v, input bit slp,
    output int ss, output int ee);
    int t0;
    vin <= v;
    wr(SACC_OFS_CTRL, {ck, 1'b0, ch, 3'b101});
    // Sleep lands in the cycle right after the start request
    if (slp) i_sleep <= 1'b1;
    t0 = cyc;
    wait_on(0);
    ss = cyc - t0;
    chk(o_chan_sel, ch);
    chk(o_analog_pwr, 1);
    if (ck == SACC_CLK_DIV32) begin
      rd(SACC_OFS_CTRL, d);
      chk(d[SACC_BIT_GO], 1);
    end
    wait_on(1);
    ee = cyc - t0;
    rd(SACC_OFS_RESULT, d);
    chk(d, v);
    rd(SACC_OFS_CTRL, d);
    chk(d, {ck, 1'b0, ch, 3'b011});
    wr(SACC_OFS_IRQ_MASK, 8'h00);
    @(posedge i_ref_clk);
    #1;
    chk(o_irq, 0);
    wr(SACC_OFS_IRQ_MASK, 8'h01);
    wr(SACC_OFS_IRQ_STAT, 8'h00);
    rd(SACC_OFS_IRQ_STAT, d);
    chk(d, 1);
    wr(SACC_OFS_IRQ_STAT, 8'h01);
    @(posedge i_ref_clk);
    #1;
    chk(o_irq, 0);
    wr(SACC_OFS_CTRL, {ck, 1'b0, ch, 3'b001});
    rd(SACC_OFS_CTRL, d);
    chk(d[SACC_BIT_DONE], 0);
  endtask
  initial begin
    {i_addr, i_wdata, i_wr, i_rd, i_sleep, i_int_en, i_rstn} = '0;
    vin = 8'h00;
    repeat (3) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rd(SACC_OFS_CTRL, d);
    chk(d, SACC_CTRL_RST);
    rd(SACC_OFS_PCFG, d);
    chk(d, {6'h00, SACC_PCFG_RST});
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][31:24], d);
      chk(d, rows[i][15:8]);
      case (rows[i][31:24])
        SACC_OFS_CTRL: chk(o_chan_sel, rows[i][7:0]);
        SACC_OFS_PCFG: chk(o_pin_func, rows[i][7:0]);
        SACC_OFS_AUX: chk(o_ref_pin_sel, rows[i][7:0]);
        default: chk(o_irq, 0);
      endcase
    end
    for (k = 0; k < 3; k++) conv(ckt[k], k[1:0], vt[k], 1'b0, ts[k], te[k]);
    chk(ts[2] - ts[0] >= 4 && ts[2] - ts[0] <= 7, 1);
    chk((te[1] - ts[1]) - (te[0] - ts[0]) <= 333 && (te[1] - ts[1]) - (te[0] - ts[0]) >= 327, 1);
    chk((te[2] - ts[2]) - (te[0] - ts[0]) + 3 <= 28 && (te[2] - ts[2]) - (te[0] - ts[0]) >= 19, 1);
    i_int_en <= 1'b1;
    conv(SACC_CLK_RC, 2'h1, 8'h81, 1'b1, s, e);
    chk(wake_n, 1);
    i_sleep <= 1'b0;
    i_int_en <= 1'b0;
    conv(SACC_CLK_RC, 2'h3, 8'h3c, 1'b1, s, e);
    chk(wake_n, 1);
    i_sleep <= 1'b0;
    k = samp_n;
    wr(SACC_OFS_CTRL, 8'h04);
    repeat (30) @(posedge i_ref_clk);
    #1;
    chk(o_analog_pwr, 0);
    chk(samp_n, k);
    vin <= 8'h77;
    wr(SACC_OFS_CTRL, 8'h85);
    wait_on(0);
    repeat (20) @(posedge i_ref_clk);
    i_rstn <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    chk({o_dac_code, o_sample, o_analog_pwr, o_irq}, 0);
    @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    rd(SACC_OFS_CTRL, d);
    chk(d, SACC_CTRL_RST);
    rd(SACC_OFS_PCFG, d);
    chk(d, {6'h00, SACC_PCFG_RST});
    rd(SACC_OFS_RESULT, d);
    chk(d, 8'h3c);
    wr(SACC_OFS_CTRL, 8'h05);
    i_sleep <= 1'b1;
    repeat (60) @(posedge i_ref_clk);
    #1;
    chk(o_analog_pwr, 0);
    rd(SACC_OFS_IRQ_STAT, d);
    chk(d, 0);
    rd(SACC_OFS_CTRL, d);
    chk(d[SACC_BIT_ON], 1);
    end_sim();
  end
endmodule
